// ### core/adsp_out_shift.sv
// Result shifter driving the serial output on the serial clock.
// Assumes the result word is held stable while chip select is low.
`timescale 1ns/1ps
`default_nettype none

module adsp_out_shift (
  // Link clock and select
  input  wire logic        sclk,
  input  wire logic        rst,
  input  wire logic        cs_n,
  // Word and mode from the core
  input  wire logic [15:0] word,
  input  wire logic        ext_mode,
  // Output pin
  output logic             serial_out,
  output logic             serial_out_oe
);

  logic        mode_s1_r;
  logic        mode_s2_r;
  logic        run_r;
  logic [15:0] sh_r;
  logic        fall_r;
  logic        rise_r;

  // Mode is quasi-static; synchronised on link edges
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
    end else begin
      mode_s1_r <= ext_mode;
      mode_s2_r <= mode_s1_r;
    end
  end

  // Parallel to serial; word taken on the first falling edge of the frame
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      run_r  <= 1'b0;
      sh_r   <= 16'h0000;
      fall_r <= 1'b0;
    end else if (!run_r) begin
      run_r  <= 1'b1;
      fall_r <= word[15];
      sh_r   <= {word[14:0], 1'b0};
    end else begin
      fall_r <= sh_r[15];
      sh_r   <= {sh_r[14:0], 1'b0};
    end
  end

  // Rising-edge copy for the external clock mode
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n)
      rise_r <= 1'b0;
    else
      rise_r <= fall_r;
  end

  assign serial_out    = mode_s2_r ? rise_r : fall_r;
  assign serial_out_oe = ~cs_n;

endmodule // adsp_out_shift

`default_nettype wire

// ### core/adsp_pkg.sv
// Constants and decode helpers for the serial command port.
// Assumes a 250 MHz core clock and a serial clock from the bus master.
`default_nettype none

package adsp_pkg;

  // Core clock and wake-up time before a result may be shifted out
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAKE_NS       = 100;
  localparam int WAKE_CYC      = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset values
  localparam logic [7:0]  SETUP_RST = 8'h28;
  localparam logic [7:0]  ZERO8     = 8'h00;
  localparam logic [15:0] DAC_HIGH  = 16'h0FFF;
  localparam logic [15:0] DAC_LOW   = 16'h0000;

  // Setup byte fields
  localparam int CKSEL_HI = 5;
  localparam int CKSEL_LO = 4;
  localparam int DIFF_HI  = 1;
  localparam int DIFF_LO  = 0;

  // Clock modes
  localparam logic [1:0] CK_CNV_INT = 2'b00;
  localparam logic [1:0] CK_CNV_EXT = 2'b01;
  localparam logic [1:0] CK_EXT     = 2'b11;

  // Second setup byte targets
  localparam logic [1:0] DIFF_UNI = 2'b10;
  localparam logic [1:0] DIFF_BIP = 2'b11;

  // Whole GPIO command codes
  localparam logic [7:0] GPIO_CFG = 8'h03;
  localparam logic [7:0] GPIO_WR  = 8'h02;
  localparam logic [7:0] GPIO_RD  = 8'h01;

  // Bytes in a whole transfer, command byte included
  function automatic logic [1:0] adsp_cmd_bytes(input logic [7:0] c);
    logic [1:0] n;
    n = 2'd1;
    if (c[7])
      n = 2'd1;
    else if (c[6])
      n = (c[DIFF_HI:DIFF_LO] == DIFF_UNI || c[DIFF_HI:DIFF_LO] == DIFF_BIP)
          ? 2'd2 : 2'd1;
    else if (c[5])
      n = 2'd1;
    else if (c[4])
      n = 2'd3;
    else if (c[3])
      n = 2'd1;
    else if (c == GPIO_CFG || c == GPIO_WR)
      n = 2'd2;
    return n;
  endfunction

  function automatic logic adsp_cmd_gpio(input logic [7:0] c);
    return c == GPIO_CFG || c == GPIO_WR || c == GPIO_RD;
  endfunction

endpackage

`default_nettype wire

// ### core/adsp_port.sv
// Serial command port: command and data capture, register file, results.
// Assumes an SPI master on the link and ADC, DAC and GPIO logic outside.
//
// What this block does
// - Clock polarity equals phase; idle either level
// - Chip select falling starts a new input
// - Input sampled on serial clock falling edges
// - Clock modes 00-10: output changes falling edge
// - Clock mode 11: output changes rising edge
// - First eight bits, MSB first, are command
// - Command sets length 8/16/24 and target
// - Chip select high returns port to idle
// - DAC write 0001XXXX plus two data bytes
// - Setup command second byte sets uni/bipolar
// - GPIO write carries exactly one data byte
// - Without GPIO pins, GPIO commands ignored
// - Two's complement for bipolar and temperature
// - Conversion and setup registers hold their fields
// - Conversion start pin honoured when assigned
// - Parallel result serialised after wake-up delay
// - Output high impedance while chip select high
// - Registers reset zero, setup to 0x28
// - Clock modes 00-10: done low at finish, high on start
`timescale 1ns/1ps
`default_nettype none

module adsp_port #(
  parameter bit HAS_GPIO = 1'b1
) (
  // Core clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Serial link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe,
  // Pins and straps
  input  wire logic        conversion_start_n,
  input  wire logic        res_sel,
  output logic             conversion_done_n,
  // ADC side
  input  wire logic        adc_done,
  input  wire logic        adc_result_valid,
  input  wire logic [11:0] adc_result,
  input  wire logic        adc_result_temp,
  input  wire logic        adc_result_diff,
  input  wire logic [1:0]  adc_result_pair,
  output logic             conv_write,
  output logic             conv_request,
  output logic [7:0]       conv_cfg,
  output logic [7:0]       setup_cfg,
  output logic [7:0]       unipolar_cfg,
  output logic [7:0]       bipolar_cfg,
  output logic [7:0]       avg_cfg,
  // Reset command
  output logic [7:0]       reset_cfg,
  output logic             reset_req,
  // DAC side
  output logic [15:0]      dac_word,
  output logic             dac_load,
  // GPIO side
  output logic [7:0]       gpio_cfg,
  output logic [7:0]       gpio_wr,
  output logic             gpio_read_req
);

  typedef enum logic [1:0] {
    ST_CMD  = 2'b00,
    ST_DATA = 2'b01,
    ST_DONE = 2'b10
  } adsp_link_e;

  // Link domain
  adsp_link_e  st_r;
  adsp_link_e  st_nxt;
  logic [4:0]  cnt_r;
  logic [23:0] sh_r;
  logic [1:0]  need_r;
  logic [7:0]  cmd_r;
  logic [7:0]  lk_cmd_r;
  logic [15:0] lk_dat_r;
  logic        lk_tgl_r;

  wire logic [23:0] sh_nxt   = {sh_r[22:0], serial_in};
  wire logic        byte_end = cnt_r[2:0] == 3'h7;
  wire logic [1:0]  cmd_len  = adsp_pkg::adsp_cmd_bytes(sh_nxt[7:0]);
  wire logic        cmd_end  = st_r == ST_CMD && byte_end;
  wire logic        last_dat = st_r == ST_DATA && byte_end &&
                               (cnt_r[4:3] + 2'd1) == need_r;
  wire logic        done_now = (cmd_end && cmd_len == 2'd1) || last_dat;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_CMD:  if (cmd_end) st_nxt = (cmd_len == 2'd1) ? ST_DONE : ST_DATA;
      ST_DATA: if (last_dat) st_nxt = ST_DONE;
      ST_DONE: st_nxt = ST_DONE;
      default: st_nxt = ST_CMD;
    endcase
  end

  // Chip select high clears the frame; partial frames never toggle
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      st_r   <= ST_CMD;
      cnt_r  <= 5'd0;
      sh_r   <= 24'h000000;
      need_r <= 2'd1;
      cmd_r  <= adsp_pkg::ZERO8;
    end else begin
      st_r  <= st_nxt;
      sh_r  <= sh_nxt;
      if (st_r != ST_DONE)
        cnt_r <= cnt_r + 5'd1;
      if (cmd_end) begin
        cmd_r  <= sh_nxt[7:0];
        need_r <= cmd_len;
      end
    end
  end

  // Frame words handed to the core; only changed with the toggle
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      lk_cmd_r <= adsp_pkg::ZERO8;
      lk_dat_r <= 16'h0000;
      lk_tgl_r <= 1'b0;
    end else if (done_now && !cs_n) begin
      lk_cmd_r <= cmd_end ? sh_nxt[7:0] : cmd_r;
      lk_dat_r <= sh_nxt[15:0];
      lk_tgl_r <= ~lk_tgl_r;
    end
  end

  cnt_bound_a: assert property (
    @(negedge sclk) disable iff (cs_n)
    cnt_r <= 5'd24)
    else $error("link bit count beyond 24");

  data_after_cmd_a: assert property (
    @(negedge sclk) disable iff (cs_n)
    st_r == ST_DATA |-> cnt_r >= 5'd8)
    else $error("data phase before eight command bits");

  // Core domain
  logic [2:0]  tg_r;
  logic [2:0]  cs_r;
  logic [2:0]  cn_r;
  logic [1:0]  rs_r;
  logic [1:0]  init_r;
  logic [7:0]  conv_r;
  logic [7:0]  setup_r;
  logic [7:0]  uni_r;
  logic [7:0]  bip_r;
  logic [7:0]  avg_r;
  logic [7:0]  rcfg_r;
  logic [15:0] dac_r;
  logic [7:0]  gcfg_r;
  logic [7:0]  gwr_r;
  logic        conv_write_r;
  logic        conv_req_r;
  logic        reset_req_r;
  logic        dac_load_r;
  logic        gpio_rd_r;
  logic        eoc_n_r;
  logic        eoc_n_nxt;
  logic [15:0] pend_r;
  logic [15:0] hold_r;
  logic [5:0]  wake_r;

  // Pin and toggle synchronisers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tg_r <= 3'h0;
      cs_r <= 3'h7;
      cn_r <= 3'h7;
      rs_r <= 2'h0;
    end else begin
      tg_r <= {tg_r[1:0], lk_tgl_r};
      cs_r <= {cs_r[1:0], cs_n};
      cn_r <= {cn_r[1:0], conversion_start_n};
      rs_r <= {rs_r[0], res_sel};
    end
  end

  wire logic       frame_ev = tg_r[2] ^ tg_r[1];
  wire logic       cs_fall  = cs_r[2] & ~cs_r[1];
  wire logic       cs_idle  = cs_r[1];
  wire logic       cn_fall  = cn_r[2] & ~cn_r[1];
  wire logic [7:0] fc       = lk_cmd_r;
  wire logic [7:0] fd       = lk_dat_r[7:0];
  wire logic [1:0] cksel    = setup_r[adsp_pkg::CKSEL_HI:adsp_pkg::CKSEL_LO];
  wire logic [1:0] fdiff    = fc[adsp_pkg::DIFF_HI:adsp_pkg::DIFF_LO];
  wire logic       cnv_fn   = cksel == adsp_pkg::CK_CNV_INT ||
                              cksel == adsp_pkg::CK_CNV_EXT;
  wire logic       ext_mode = cksel == adsp_pkg::CK_EXT;

  // Command decode of a completed frame
  wire logic is_conv  = frame_ev && fc[7];
  wire logic is_setup = frame_ev && fc[7:6] == 2'b01;
  wire logic is_avg   = frame_ev && fc[7:5] == 3'b001;
  wire logic is_dac   = frame_ev && fc[7:4] == 4'b0001;
  wire logic is_rst   = frame_ev && fc[7:3] == 5'b00001;
  wire logic gpio_ok  = frame_ev && HAS_GPIO &&
                        adsp_pkg::adsp_cmd_gpio(fc);
  wire logic is_gcfg  = gpio_ok && fc == adsp_pkg::GPIO_CFG;
  wire logic is_gwr   = gpio_ok && fc == adsp_pkg::GPIO_WR;
  wire logic is_grd   = gpio_ok && fc == adsp_pkg::GPIO_RD;

  // Configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_r  <= adsp_pkg::ZERO8;
      setup_r <= adsp_pkg::SETUP_RST;
      uni_r   <= adsp_pkg::ZERO8;
      bip_r   <= adsp_pkg::ZERO8;
      avg_r   <= adsp_pkg::ZERO8;
      rcfg_r  <= adsp_pkg::ZERO8;
      gcfg_r  <= adsp_pkg::ZERO8;
      gwr_r   <= adsp_pkg::ZERO8;
    end else begin
      if (is_conv)
        conv_r <= fc;
      if (is_setup) begin
        setup_r <= fc;
        if (fdiff == adsp_pkg::DIFF_UNI)
          uni_r <= fd;
        if (fdiff == adsp_pkg::DIFF_BIP)
          bip_r <= fd;
      end
      if (is_avg)
        avg_r <= fc;
      if (is_rst)
        rcfg_r <= fc;
      if (is_gcfg)
        gcfg_r <= fd;
      if (is_gwr)
        gwr_r <= fd;
    end
  end

  // DAC word; power-up value follows the strap once synchronised
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init_r <= 2'd0;
      dac_r  <= adsp_pkg::DAC_LOW;
    end else if (init_r != 2'd3) begin
      init_r <= init_r + 2'd1;
      if (init_r == 2'd2)
        dac_r <= rs_r[1] ? adsp_pkg::DAC_HIGH : adsp_pkg::DAC_LOW;
    end else if (is_dac) begin
      dac_r <= lk_dat_r;
    end
  end

  // One-cycle strobes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_write_r <= 1'b0;
      conv_req_r   <= 1'b0;
      reset_req_r  <= 1'b0;
      dac_load_r   <= 1'b0;
      gpio_rd_r    <= 1'b0;
    end else begin
      conv_write_r <= is_conv;
      conv_req_r   <= cn_fall && cnv_fn;
      reset_req_r  <= is_rst;
      dac_load_r   <= is_dac && init_r == 2'd3;
      gpio_rd_r    <= is_grd;
    end
  end

  // End-of-conversion flag; finishing wins over a same-cycle release
  always_comb begin
    eoc_n_nxt = eoc_n_r;
    if (ext_mode)
      eoc_n_nxt = 1'b1;
    else if (adc_done)
      eoc_n_nxt = 1'b0;
    else if (cs_fall || (cn_fall && cnv_fn))
      eoc_n_nxt = 1'b1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      eoc_n_r <= 1'b1;
    else
      eoc_n_r <= eoc_n_nxt;
  end

  // Result coding and wake-up delay before the shifter may take it
  wire logic        twos     = adc_result_temp ||
                               (adc_result_diff && bip_r[adc_result_pair]);
  wire logic [15:0] res_word = twos ?
                               {{5{~adc_result[11]}}, adc_result[10:0]} :
                               {4'h0, adc_result};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_r <= 16'h0000;
      hold_r <= 16'h0000;
      wake_r <= 6'd0;
    end else if (adc_result_valid) begin
      pend_r <= res_word;
      wake_r <= 6'(adsp_pkg::WAKE_CYC);
    end else if (wake_r > 6'd1) begin
      wake_r <= wake_r - 6'd1;
    end else if (wake_r == 6'd1 && cs_idle) begin
      // Word only changes while the link is idle
      hold_r <= pend_r;
      wake_r <= 6'd0;
    end
  end

  adsp_out_shift u_out (
    .sclk          (sclk),
    .rst           (rst),
    .cs_n          (cs_n),
    .word          (hold_r),
    .ext_mode      (ext_mode),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe)
  );

  assign conversion_done_n = eoc_n_r;
  assign conv_write        = conv_write_r;
  assign conv_request      = conv_req_r;
  assign conv_cfg          = conv_r;
  assign setup_cfg         = setup_r;
  assign unipolar_cfg      = uni_r;
  assign bipolar_cfg       = bip_r;
  assign avg_cfg           = avg_r;
  assign reset_cfg         = rcfg_r;
  assign reset_req         = reset_req_r;
  assign dac_word          = dac_r;
  assign dac_load          = dac_load_r;
  assign gpio_cfg          = gcfg_r;
  assign gpio_wr           = gwr_r;
  assign gpio_read_req     = gpio_rd_r;

  // Checks
  sequence cs_start_s;
    cs_fall && !adc_done && !ext_mode;
  endsequence

  eoc_release_a: assert property (
    @(posedge clock) disable iff (rst)
    cs_start_s |=> conversion_done_n)
    else $error("done flag not released on select");

  eoc_finish_a: assert property (
    @(posedge clock) disable iff (rst)
    adc_done && !ext_mode |=> !conversion_done_n)
    else $error("done flag not set on finish");

  eoc_ext_a: assert property (
    @(posedge clock) disable iff (rst)
    ext_mode |=> conversion_done_n)
    else $error("done flag low in external clock mode");

  setup_write_a: assert property (
    @(posedge clock) disable iff (rst)
    is_setup |=> setup_cfg == $past(lk_cmd_r))
    else $error("setup register not written");

  dac_write_a: assert property (
    @(posedge clock) disable iff (rst)
    is_dac && init_r == 2'd3 |=> dac_word == $past(lk_dat_r) && dac_load)
    else $error("DAC word not written");

  gpio_ignore_a: assert property (
    @(posedge clock) disable iff (rst)
    frame_ev && !HAS_GPIO |=> $stable(gpio_wr) && $stable(gpio_cfg))
    else $error("GPIO state changed without GPIO pins");

  cnv_request_a: assert property (
    @(posedge clock) disable iff (rst)
    cn_fall && cnv_fn |=> conv_request ##1 !conv_request)
    else $error("conversion start not honoured");

  cnv_block_a: assert property (
    @(posedge clock) disable iff (rst)
    !cnv_fn |=> !conv_request)
    else $error("conversion start honoured when unassigned");

  no_frame_a: assert property (
    @(posedge clock) disable iff (rst)
    !frame_ev |=> $stable(conv_cfg) && $stable(bipolar_cfg))
    else $error("register changed without a frame");

endmodule // adsp_port

`default_nettype wire

// ### tb/adsp_master_model.sv
// Bus master model for the serial command port link.
// Assumes the bench calls xfer only with chip select idle.
`timescale 1ns/1ps
`default_nettype none

module adsp_master_model (
  // Link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end

  // Half-ns offset keeps link edges off the core clock edges
  task automatic xfer(input logic cpol, input logic [23:0] d,
                      input int n, output logic [23:0] q);
    q = 24'h0;
    sclk = cpol;
    #40.5;
    cs_n = 1'b0;
    #32;
    for (int i = 0; i < n; i++) begin
      serial_in = d[23-i];
      sclk = 1'b1;
      #16;
      q = {q[22:0], serial_out};
      #16;
      sclk = 1'b0;
      #32;
    end
    sclk = cpol;
    #32;
    cs_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    serial_in = ~serial_in;
    #64.5;
  endtask
endmodule // adsp_master_model

`default_nettype wire

// ### tb/adsp_port_tb.sv
// Bench for the serial command port: commands, results, end of conversion.
// Assumes adsp_master_model drives the link with a 64 ns clock.
`timescale 1ns/1ps
`default_nettype none

module adsp_port_tb;
  typedef struct packed {
    logic [4:0]  p;
    logic [7:0]  cv, su, un, bp, av, rs, gc, gw;
    logic [15:0] dw;
  } adsp_snap_s;

  logic        clock, rst, res_sel, conversion_start_n;
  logic        adc_done, adc_result_valid, adc_result_temp, adc_result_diff;
  logic [1:0]  adc_result_pair;
  logic [11:0] adc_result;
  logic [15:0] seed;
  int          errors, samples_checked;
  adsp_snap_s  seen, prev_r, e, q[$];
  wire logic   sclk, cs_n, serial_in, serial_out, serial_out_oe, miso;
  wire logic   conversion_done_n;
  wire logic [4:0]  p;
  wire logic [7:0]  cv, su, un, bp, av, rs, gc, gw;
  wire logic [15:0] dw;
  logic [7:0]  cmds [10] = '{8'h95, 8'h6B, 8'h6A, 8'h3C, 8'h1A,
                             8'h0B, 8'h03, 8'h02, 8'h01, 8'h00};

  assign miso = serial_out_oe ? serial_out : 1'bz;
  assign seen = {p, cv, su, un, bp, av, rs, gc, gw, dw};

  adsp_port adsp_port_i (
    .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .conversion_start_n(conversion_start_n), .res_sel(res_sel),
    .conversion_done_n(conversion_done_n), .adc_done(adc_done),
    .adc_result_valid(adc_result_valid), .adc_result(adc_result),
    .adc_result_temp(adc_result_temp), .adc_result_diff(adc_result_diff),
    .adc_result_pair(adc_result_pair), .conv_write(p[4]), .conv_request(p[3]),
    .conv_cfg(cv), .setup_cfg(su), .unipolar_cfg(un),
    .bipolar_cfg(bp), .avg_cfg(av), .reset_cfg(rs), .reset_req(p[1]),
    .dac_word(dw), .dac_load(p[2]), .gpio_cfg(gc), .gpio_wr(gw),
    .gpio_read_req(p[0])
  );

  adsp_master_model adsp_master_model_i (
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .serial_out(miso)
  );

  // Variant without GPIO pins on the same link and ADC inputs
  if (1) begin : no_gpio
    wire logic [7:0] gc, gw;
    wire logic       rd;
    logic            rd_any = 1'b0;
    always @(posedge clock) if (rd) rd_any <= 1'b1;
    adsp_port #(.HAS_GPIO(1'b0)) adsp_port_i (
      .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n),
      .serial_in(serial_in), .serial_out(), .serial_out_oe(),
      .conversion_start_n(conversion_start_n), .res_sel(res_sel),
      .conversion_done_n(), .adc_done(adc_done),
      .adc_result_valid(adc_result_valid), .adc_result(adc_result),
      .adc_result_temp(adc_result_temp), .adc_result_diff(adc_result_diff),
      .adc_result_pair(adc_result_pair), .conv_write(), .conv_request(),
      .conv_cfg(), .setup_cfg(), .unipolar_cfg(), .bipolar_cfg(),
      .avg_cfg(), .reset_cfg(), .reset_req(), .dac_word(), .dac_load(),
      .gpio_cfg(gc), .gpio_wr(gw), .gpio_read_req(rd)
    );
  end

  always #2 clock = ~clock;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int blen(input logic [7:0] c);
    casez (c)
      8'b1???????: return 8;
      8'b01??????: return c[1] ? 16 : 8;
      8'b001?????: return 8;
      8'b0001????: return 24;
      8'h02, 8'h03: return 16;
      default: return 8;
    endcase
  endfunction

  task automatic check(input string what, input logic [84:0] got, want);
    samples_checked++;
    if (got !== want) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, want, got);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Oldest note is matched against every visible result
  always @(posedge clock) begin
    if (rst)
      prev_r <= seen;
    else if (|seen.p || seen[79:0] !== prev_r[79:0]) begin
      prev_r <= seen;
      if (q.size() == 0)
        check("event", 1, 0);
      else
        check("result", seen, q.pop_front());
    end
  end

  always @(negedge clock) if (!rst) check("oe", serial_out_oe, !cs_n);

  task automatic send(input logic cpol, input logic [7:0] c, b1, b2,
                      input int n);
    adsp_snap_s  w;
    logic [23:0] rx;
    w = e;
    w.p = {c[7], 1'b0, c[7:4] == 4'h1, c[7:3] == 5'h01, c == 8'h01};
    casez (c)
      8'b1???????: w.cv = c;
      8'b01??????: w.su = c;
      8'b001?????: w.av = c;
      8'b0001????: w.dw = {b1, b2};
      8'b00001???: w.rs = c;
      8'h03: w.gc = b1;
      8'h02: w.gw = b1;
      default: ;
    endcase
    if (c[7:6] == 2'b01 && c[1:0] == 2'b10) w.un = b1;
    if (c[7:6] == 2'b01 && c[1:0] == 2'b11) w.bp = b1;
    if (n >= blen(c)) begin
      if (w !== e) q.push_back(w);
      e = w;
      e.p = 5'h00;
    end
    adsp_master_model_i.xfer(cpol, {c, b1, b2}, n, rx);
  endtask

  task automatic result(input logic cpol, input logic t, input logic d);
    logic [23:0] rx;
    logic [11:0] r;
    logic        tc;
    seed = lfsr(seed);
    r = seed[11:0];
    tc = t || (d && e.bp[seed[13:12]]);
    @(posedge clock);
    #1 adc_result = r;
    adc_result_temp = t;
    adc_result_diff = d;
    adc_result_pair = seed[13:12];
    adc_result_valid = 1'b1;
    @(posedge clock);
    #1 adc_result_valid = 1'b0;
    repeat (30) @(posedge clock);
    adsp_master_model_i.xfer(cpol, 24'h0, 24, rx);
    check("dout", rx[22:7], tc ? {{5{~r[11]}}, r[10:0]} : {4'h0, r});
  endtask

  task automatic done_pulse(input logic want);
    @(posedge clock);
    #1 adc_done = 1'b1;
    @(posedge clock);
    #1 adc_done = 1'b0;
    @(posedge clock);
    #1 check("done", conversion_done_n, want);
  endtask

  task automatic start_pin(input logic req);
    adsp_snap_s w;
    w = e;
    w.p = 5'h08;
    if (req) q.push_back(w);
    @(posedge clock);
    #1 conversion_start_n = 1'b0;
    repeat (8) @(posedge clock);
    #1 check("done", conversion_done_n, 1);
    conversion_start_n = 1'b1;
    repeat (8) @(posedge clock);
  endtask

  initial begin
    #200000;
    errors++;
    print_verdict;
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    res_sel = 1'b1;
    conversion_start_n = 1'b1;
    adc_done = 1'b0;
    adc_result_valid = 1'b0;
    adc_result_temp = 1'b0;
    adc_result_diff = 1'b0;
    adc_result_pair = 2'b00;
    adc_result = 12'h000;
    seed = 16'h676A;
    errors = 0;
    samples_checked = 0;
    e = '0;
    e.su = 8'h28;
    @(posedge clock);
    #1 check("reset", seen, e);
    e.dw = 16'h0FFF;
    q.push_back(e);
    @(posedge clock);
    #1 rst = 1'b0;
    repeat (10) @(posedge clock);
    $display("test reset done");
    for (int j = 0; j < 2; j++) begin
      foreach (cmds[i]) begin
        seed = lfsr(seed);
        send(j[0], cmds[i], seed[7:0], seed[15:8],
             j ? 24 : blen(cmds[i]));
      end
    end
    $display("test commands done");
    send(1'b0, 8'h1C, 8'hA5, 8'h5A, 16);
    send(1'b1, 8'h95, 8'h00, 8'h00, 5);
    send(1'b1, 8'h6B, 8'hC3, 8'h00, 16);
    $display("test partial done");
    result(1'b0, 1'b0, 1'b1);
    result(1'b1, 1'b1, 1'b0);
    $display("test results done");
    done_pulse(1'b0);
    send(1'b0, 8'h00, 8'h00, 8'h00, 8);
    #1 check("done", conversion_done_n, 1);
    start_pin(1'b0);
    send(1'b0, 8'h48, 8'h00, 8'h00, 8);
    done_pulse(1'b0);
    start_pin(1'b1);
    send(1'b0, 8'h78, 8'h00, 8'h00, 8);
    done_pulse(1'b1);
    send(1'b1, 8'h00, 8'h00, 8'h00, 8);
    result(1'b0, 1'b0, 1'b0);
    $display("test modes done");
    repeat (20) @(posedge clock);
    check("pending", q.size(), 0);
    check("no gpio", {no_gpio.rd_any, no_gpio.gc, no_gpio.gw}, 17'h00000);
    print_verdict;
  end
endmodule // adsp_port_tb

`default_nettype wire
